// ### src/wwd_pkg.sv
// windowed watchdog: shared constants, register layout and types
// assumes a single 25 MHz clock and a one-word register port
//
// Contract
// - restart write needs key byte, else ignored
// - keyed restart bit one within window reloads counter
// - counter loads from mode reload field
// - irq enable bit gates faults onto interrupt
// - reset enable bit gates faults onto reset
// - processor-only bit picks reset scope
// - restart accepted when counter within window
// - restart above window is an error
// - debug halt bit stops counter in debug
// - idle halt bit stops counter in idle
// - disable bit stops the timer
// - underflow flag sticky until status read
// - error flag sticky until status read
// - tick is slow clock over 128, restartable
// - mode writable once, write reloads counter
// - status read clears flags, irq, fault
// - underflow sets flag and maybe fault
package wwd_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_RESTART = 8'h00;
  localparam logic [7:0] OFS_MODE = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h10;
  localparam logic [7:0] OFS_IRQ_EN = 8'h14;

  // ---------------------------------------------------------------
  // fields and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RESTART_KEY = 8'ha5;
  localparam int KEY_LSB = 24;
  localparam int RESTART_BIT = 0;
  localparam logic [31:0] MODE_RESET = 32'h3fff2fff;
  localparam logic [31:0] MODE_MASK = 32'h3fffffff;
  localparam int CNT_W = 12;
  localparam int SLOW_DIV = 128;
  localparam int EVT_W = 2;
  localparam logic [1:0] EVT_RESET = 2'h0;

  // mode register layout, bit 31 down to 0
  typedef struct packed {
    logic [1:0] rsvd;
    logic idle_halt;
    logic debug_halt;
    logic [11:0] restart_window_limit;
    logic timer_disable;
    logic processor_only_reset;
    logic fault_reset_enable;
    logic fault_irq_enable;
    logic [11:0] counter_reload_value;
  } wwd_mode_t;

  // fault events, also the status and irq bit layout
  typedef struct packed {
    logic restart_error;
    logic underflow;
  } wwd_evt_t;

endpackage

// ### src/wwd_prescale.sv
// windowed watchdog: slow clock divider giving the count tick
// assumes slow_tick_i is a one-cycle enable synchronous to clk_i
`timescale 1ns/1ps

module wwd_prescale #(
  parameter int DIV = wwd_pkg::SLOW_DIV
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic slow_tick_i,
  input wire logic restart_i,
  output logic tick_o
);

  localparam int W = $clog2(DIV);
  localparam logic [W-1:0] LAST = W'(DIV - 1);

  logic [W-1:0] div_q;
  logic [W-1:0] div_d;

  // divide by DIV, cleared by any restart
  always_comb begin
    div_d = div_q;
    if (restart_i) begin
      div_d = '0;
    end else if (slow_tick_i) begin
      div_d = (div_q == LAST) ? '0 : div_q + W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_q <= '0;
    end else begin
      div_q <= div_d;
    end
  end

  assign tick_o = slow_tick_i && !restart_i && (div_q == LAST);

endmodule

// ### src/wwd_top.sv
// windowed watchdog: registers, down counter, flags, irq and fault
// assumes one clock, synchronous reset and a single-cycle reg port
`timescale 1ns/1ps

module wwd_top #(
  parameter int DIV = wwd_pkg::SLOW_DIV
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic slow_tick_i,
  input wire logic debug_state_i,
  input wire logic idle_state_i,
  output logic irq_o,
  output logic fault_all_o,
  output logic fault_proc_o
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  wwd_pkg::wwd_mode_t mode_q, mode_d;
  logic mode_locked_q, mode_locked_d;
  logic [11:0] cnt_q, cnt_d;
  wwd_pkg::wwd_evt_t flags_q, flags_d;
  wwd_pkg::wwd_evt_t irq_stat_q, irq_stat_d;
  wwd_pkg::wwd_evt_t irq_en_q, irq_en_d;
  logic irq_q, irq_d;
  logic fault_all_q, fault_all_d;
  logic fault_proc_q, fault_proc_d;
  logic [31:0] rdata_q, rdata_d;

  // ---------------------------------------------------------------
  // access decode
  // ---------------------------------------------------------------
  logic key_ok;
  logic wr_restart;
  logic restart_ok;
  logic restart_err;
  logic mode_wr;
  logic status_rd;
  logic irq_clr_wr;
  logic irq_en_wr;
  logic halted;
  logic tick;
  logic count_en;
  logic underflow;
  wwd_pkg::wwd_evt_t evt;

  assign key_ok = wdata_i[wwd_pkg::KEY_LSB +: 8] == wwd_pkg::RESTART_KEY;
  assign wr_restart = wr_i && (addr_i == wwd_pkg::OFS_RESTART) && key_ok
    && wdata_i[wwd_pkg::RESTART_BIT];
  assign restart_ok = wr_restart
    && (cnt_q <= mode_q.restart_window_limit);
  assign restart_err = wr_restart && !restart_ok;
  assign mode_wr = wr_i && (addr_i == wwd_pkg::OFS_MODE) && !mode_locked_q;
  assign status_rd = rd_i && (addr_i == wwd_pkg::OFS_STATUS);
  assign irq_clr_wr = wr_i && (addr_i == wwd_pkg::OFS_IRQ_CLR);
  assign irq_en_wr = wr_i && (addr_i == wwd_pkg::OFS_IRQ_EN);

  // count gating: disable, debug halt, idle halt
  assign halted = mode_q.timer_disable
    || (mode_q.debug_halt && debug_state_i)
    || (mode_q.idle_halt && idle_state_i);

  // ---------------------------------------------------------------
  // slow clock divider
  // ---------------------------------------------------------------
  wwd_prescale #(
    .DIV(DIV)
  ) u_prescale (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .slow_tick_i(slow_tick_i),
    .restart_i(restart_ok || mode_wr),
    .tick_o(tick)
  );

  assign count_en = tick && !halted;
  assign underflow = count_en && (cnt_q == '0);
  assign evt = '{restart_error: restart_err, underflow: underflow};

  // ---------------------------------------------------------------
  // mode register and down counter
  // ---------------------------------------------------------------
  always_comb begin
    mode_d = mode_q;
    mode_locked_d = mode_locked_q;
    cnt_d = cnt_q;
    if (mode_wr) begin
      mode_d = wwd_pkg::wwd_mode_t'(wdata_i & wwd_pkg::MODE_MASK);
      mode_locked_d = 1'b1;
      cnt_d = wdata_i[11:0];
    end else if (restart_ok) begin
      cnt_d = mode_q.counter_reload_value;
    end else if (count_en) begin
      // wrap to reload after underflow
      cnt_d = (cnt_q == '0) ? mode_q.counter_reload_value
                            : cnt_q - 12'h001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q <= wwd_pkg::wwd_mode_t'(wwd_pkg::MODE_RESET);
      mode_locked_q <= 1'b0;
      cnt_q <= wwd_pkg::MODE_RESET[11:0];
    end else begin
      mode_q <= mode_d;
      mode_locked_q <= mode_locked_d;
      cnt_q <= cnt_d;
    end
  end

  // ---------------------------------------------------------------
  // status flags, irq status and fault outputs
  // ---------------------------------------------------------------
  always_comb begin
    wwd_pkg::wwd_evt_t clr;
    clr = '0;
    if (irq_clr_wr) begin
      clr = wwd_pkg::wwd_evt_t'(wdata_i[1:0]);
    end
    if (status_rd) begin
      clr = '1;
    end
    // set wins over clear
    flags_d = evt | (status_rd ? wwd_pkg::wwd_evt_t'('0) : flags_q);
    irq_stat_d = evt | (irq_stat_q & ~clr);
    irq_en_d = irq_en_wr ? wwd_pkg::wwd_evt_t'(wdata_i[1:0]) : irq_en_q;
    irq_d = mode_q.fault_irq_enable && |(irq_stat_d & irq_en_d);
    fault_all_d = fault_all_q;
    fault_proc_d = fault_proc_q;
    if (mode_q.fault_reset_enable && |evt) begin
      fault_all_d = !mode_q.processor_only_reset;
      fault_proc_d = mode_q.processor_only_reset;
    end else if (status_rd) begin
      fault_all_d = 1'b0;
      fault_proc_d = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_q <= wwd_pkg::EVT_RESET;
      irq_stat_q <= wwd_pkg::EVT_RESET;
      irq_en_q <= wwd_pkg::EVT_RESET;
      irq_q <= 1'b0;
      fault_all_q <= 1'b0;
      fault_proc_q <= 1'b0;
    end else begin
      flags_q <= flags_d;
      irq_stat_q <= irq_stat_d;
      irq_en_q <= irq_en_d;
      irq_q <= irq_d;
      fault_all_q <= fault_all_d;
      fault_proc_q <= fault_proc_d;
    end
  end

  // ---------------------------------------------------------------
  // read data, one cycle after the strobe
  // ---------------------------------------------------------------
  always_comb begin
    rdata_d = '0;
    if (!rd_i) begin
      rdata_d = '0;
    end else if (addr_i == wwd_pkg::OFS_MODE) begin
      rdata_d = mode_q;
    end else if (addr_i == wwd_pkg::OFS_STATUS) begin
      rdata_d = {30'h0, flags_q};
    end else if (addr_i == wwd_pkg::OFS_IRQ_STAT) begin
      rdata_d = {30'h0, irq_stat_q};
    end else if (addr_i == wwd_pkg::OFS_IRQ_EN) begin
      rdata_d = {30'h0, irq_en_q};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata_o = rdata_q;
  assign irq_o = irq_q;
  assign fault_all_o = fault_all_q;
  assign fault_proc_o = fault_proc_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  logic bad_key_wr;
  assign bad_key_wr = wr_i && (addr_i == wwd_pkg::OFS_RESTART) && !key_ok;
  logic zero_bit_wr;
  assign zero_bit_wr = wr_i && (addr_i == wwd_pkg::OFS_RESTART) && key_ok
    && !wdata_i[wwd_pkg::RESTART_BIT];

  chk_key_ignore: assert property (
    bad_key_wr && !flags_q.restart_error |=> !flags_q.restart_error)
    else $error("unkeyed restart write had an effect");

  chk_restart_load: assert property (
    restart_ok |=> cnt_q == $past(mode_q.counter_reload_value))
    else $error("accepted restart did not reload counter");

  chk_window_err: assert property (
    wr_restart && cnt_q > mode_q.restart_window_limit
      |=> flags_q.restart_error && (cnt_q != mode_q.counter_reload_value
        || $past(cnt_q) == mode_q.counter_reload_value))
    else $error("out-of-window restart not flagged or reloaded");

  chk_irq_gate: assert property (
    irq_o |-> $past(mode_q.fault_irq_enable) && |(irq_stat_q & irq_en_q))
    else $error("interrupt without enabled fault");

  chk_fault_gate: assert property (
    $rose(fault_all_o || fault_proc_o) |-> $past(mode_q.fault_reset_enable)
      && $past(|evt))
    else $error("fault raised without reset enable");

  chk_fault_scope: assert property (
    $rose(fault_proc_o) |-> $past(mode_q.processor_only_reset) && !fault_all_o)
    else $error("processor-only fault with wrong scope");

  chk_halt_hold: assert property (
    halted && !mode_wr && !restart_ok |=> $stable(cnt_q))
    else $error("counter moved while halted");

  chk_status_clear: assert property (
    status_rd && !(|evt) |=> flags_q == '0 && !fault_all_o && !fault_proc_o
      ##0 !irq_o)
    else $error("status read did not clear");

  chk_unf_flag: assert property (
    underflow |=> flags_q.underflow && cnt_q == mode_q.counter_reload_value)
    else $error("underflow not flagged or not reloaded");

  chk_mode_once: assert property (
    mode_locked_q |=> $stable(mode_q))
    else $error("locked mode register changed");

  // ---------------------------------------------------------------
  // divider reference for the tick spacing check
  // ---------------------------------------------------------------
  logic [15:0] slow_seen_q, slow_seen_d;

  // slow ticks counted since the last count tick or restart
  always_comb begin
    slow_seen_d = slow_seen_q;
    if (tick || restart_ok || mode_wr) begin
      slow_seen_d = 16'h0000;
    end else if (slow_tick_i) begin
      slow_seen_d = slow_seen_q + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slow_seen_q <= 16'h0000;
    end else begin
      slow_seen_q <= slow_seen_d;
    end
  end

  chk_tick_rate: assert property (
    tick |-> slow_tick_i && slow_seen_q == 16'(DIV - 1))
    else $error("count tick not on the last slow tick of the divider");

  chk_key_hold: assert property (
    bad_key_wr && !count_en |=> $stable(cnt_q))
    else $error("unkeyed restart write moved the counter");

  chk_zero_bit: assert property (
    zero_bit_wr && !count_en |=> $stable(cnt_q) && $stable(flags_q.restart_error))
    else $error("restart write with zero bit had an effect");

  chk_irq_off: assert property (
    !mode_q.fault_irq_enable |=> !irq_o)
    else $error("interrupt raised with fault interrupt off");

  chk_fault_off: assert property (
    !mode_q.fault_reset_enable && !fault_all_o && !fault_proc_o
      |=> !fault_all_o && !fault_proc_o)
    else $error("fault raised with fault reset off");

  chk_err_flag: assert property (
    restart_err |=> flags_q.restart_error)
    else $error("restart error not flagged");

  // main scenarios worth seeing once
  cov_restart: cover property (restart_ok ##[1:500] count_en);
  cov_error: cover property (restart_err ##1 irq_o);
  cov_underflow: cover property (underflow ##1 fault_all_o);
  cov_proc: cover property (fault_proc_o ##1 status_rd);
  cov_halted_tick: cover property (halted && tick);

endmodule

// ### verif/testbench.sv
// windowed watchdog bench: registers, restart window, underflow, halt, disable
// assumes wwd_top on one 25 MHz clock, divider shortened to 4 slow ticks
`timescale 1ns/1ps

module testbench;
  localparam int DIV = 4;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic slow_tick_i = 1'b0;
  logic debug_state_i = 1'b0;
  logic idle_state_i = 1'b0;
  logic [31:0] rdata_o;
  logic irq_o;
  logic fault_all_o;
  logic fault_proc_o;
  int fails = 0;
  int total_checks = 0;

  // ----------------------------------------------------------------
  // clock and design
  // ----------------------------------------------------------------
  always #20 clk_i = ~clk_i;

  wwd_top #(.DIV(DIV)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .slow_tick_i(slow_tick_i),
    .debug_state_i(debug_state_i), .idle_state_i(idle_state_i),
    .irq_o(irq_o), .fault_all_o(fault_all_o), .fault_proc_o(fault_proc_o)
  );

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic do_reset;
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    check(name, rdata_o, exp);
  endtask

  // let flag updates land, then compare irq and both fault lines
  task automatic outs(input logic [2:0] exp);
    repeat (2) @(posedge clk_i);
    #1;
    check("irq_all_proc", {29'h0, irq_o, fault_all_o, fault_proc_o}, {29'h0, exp});
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk_i);
      slow_tick_i <= 1'b1;
      @(posedge clk_i);
      slow_tick_i <= 1'b0;
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_values;
    rd_chk("mode_reset", 8'h04, 32'h3fff2fff);
    rd_chk("status_reset", 8'h08, 32'h0);
    rd_chk("irq_en_reset", 8'h14, 32'h0);
    rd_chk("unmapped", 8'h20, 32'h0);
    outs(3'b000);
  endtask

  // reload 5, window 2, irq and all-reset faults on
  task automatic t_window_error;
    wr(8'h04, 32'h00023005);
    wr(8'h04, 32'h00008001);
    rd_chk("mode_once", 8'h04, 32'h00023005);
    wr(8'h14, 32'h3);
    rd_chk("irq_en", 8'h14, 32'h3);
    wr(8'h00, 32'h5a000001);
    wr(8'h00, 32'ha5000000);
    rd_chk("status_no_key", 8'h08, 32'h0);
    outs(3'b000);
    wr(8'h00, 32'ha5000001);
    outs(3'b110);
    wr(8'h10, 32'h2);
    outs(3'b010);
    rd_chk("irq_cleared", 8'h0c, 32'h0);
    wr(8'h14, 32'h1);
    wr(8'h00, 32'ha5000001);
    outs(3'b010);
    rd_chk("status_err", 8'h08, 32'h2);
    outs(3'b000);
  endtask

  // counter 5 reaches zero after 20 slow ticks, wraps on the 24th
  task automatic t_underflow;
    tick(22);
    wr(8'h00, 32'ha5000001);
    tick(23);
    rd_chk("status_in_window", 8'h08, 32'h0);
    outs(3'b000);
    tick(1);
    outs(3'b110);
    rd_chk("status_unf", 8'h08, 32'h1);
    outs(3'b000);
  endtask

  // debug halt on, idle halt off, processor-only reset, no irq
  task automatic t_halt;
    do_reset();
    wr(8'h04, 32'h1fff6001);
    debug_state_i <= 1'b1;
    tick(40);
    rd_chk("status_debug", 8'h08, 32'h0);
    debug_state_i <= 1'b0;
    idle_state_i <= 1'b1;
    tick(2 * DIV);
    outs(3'b001);
    idle_state_i <= 1'b0;
    rd_chk("status_idle", 8'h08, 32'h1);
  endtask

  // idle halt on, debug halt off, reload 1, no irq, no fault reset
  task automatic t_idle;
    do_reset();
    wr(8'h04, 32'h2fff0001);
    idle_state_i <= 1'b1;
    tick(40);
    rd_chk("status_idle_halt", 8'h08, 32'h0);
    idle_state_i <= 1'b0;
    debug_state_i <= 1'b1;
    tick(2 * DIV);
    outs(3'b000);
    debug_state_i <= 1'b0;
    rd_chk("status_debug_run", 8'h08, 32'h1);
  endtask

  // disabled timer, window 0, no fault reset
  task automatic t_disable;
    do_reset();
    rd_chk("mode_after_reset", 8'h04, 32'h3fff2fff);
    wr(8'h04, 32'h00008001);
    tick(40);
    rd_chk("status_disabled", 8'h08, 32'h0);
    wr(8'h00, 32'ha5000001);
    outs(3'b000);
    rd_chk("status_dis_err", 8'h08, 32'h2);
  endtask

  // ----------------------------------------------------------------
  // main sequence and hang guard
  // ----------------------------------------------------------------
  initial begin
    do_reset();
    t_reset_values();
    t_window_error();
    t_underflow();
    t_halt();
    t_idle();
    t_disable();
    test_done();
  end

  initial begin
    #4000000;
    fails++;
    $display("MISMATCH run_time expected end seen timeout");
    test_done();
  end

endmodule
